// ==== hw/apg_regs.sv ====
// Phase, gain and status/communication registers of the front end.
// Assumes a serial host on sck/cs_n/sdi/sdo, converter events on clk.
//
// Function
// - Any phase register write restarts all enabled converter channels.
// - Bits 23-12 delay channel 2 against channel 3 in master clocks.
// - Bits 11-0 delay channel 0 against channel 1 in master clocks.
// - Three-bit gain per channel; codes 0-5 give gains 1 to 32.
// - Reserved gain codes 6 and 7 act as gain one.
// - Bits 23-22 choose read stepping: map, type, group or none.
// - Bit 21 set steps write address over writable map, else fixed.
// - Bit 20 set drives ready pin high when idle, else floats.
// - Bit 19 merges ready pulses into one, timed by latest channel.
// - Bit 18 widens the link checksum to 32 bits with zeros.
// - Bits 17-16 pick output word format, reset is 24-bit.
// - Bit 15 appends a 16-bit checksum to every link sequence.
// - With bit 14 set, config checksum error holds ready pin low.
// - Flags 7-0 read zero on new data, return to one on read.
`timescale 1ns/1ps
module apg_regs
   import apg_pkg::*;
#(
   parameter logic [1:0] DEV_ADDR = 2'h1  // Arbitrary device address
)(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         sck,
   input  wire logic         cs_n,
   input  wire logic         sdi,
   output logic              sdo_out,
   output logic              sdo_oe,
   input  wire logic [7:0]   ch_new,
   input  wire logic         cfg_crc_err,
   input  wire logic [7:0]   lock_value,
   output logic              adc_restart,
   output logic [11:0]       delay_ch0_vs_ch1,
   output logic [11:0]       delay_ch2_vs_ch3,
   output logic [23:0]       gain_shift,
   output logic [1:0]        rd_incr_mode,
   output logic              wr_incr,
   output logic [1:0]        out_format,
   output logic              crc_wide,
   output logic              comm_checksum_enable,
   output logic              data_ready_output_n,
   output logic              data_ready_output_oe
);

   // -------------------------------------------------------------
   // Link side, clocked by sck
   // -------------------------------------------------------------
   apg_phase_t  phase;
   logic [4:0]  idx;
   logic [23:0] sr_in;
   logic [23:0] out_sr;
   logic [23:0] rd_word;
   logic [23:0] wr_word;
   logic [7:0]  cmd_byte;
   logic        cmd_tgl;
   logic        word_tgl;
   wire         cmd_end  = (phase == ST_CMD) && (idx == 5'h07);
   wire         word_end = (phase == ST_DATA) && (idx == 5'h17);
   wire         unit_top = (idx == 5'h00);
   wire         rd_frame = (phase == ST_DATA) && cmd_byte[CMD_RD_BIT]
                           && (cmd_byte[CMD_DEV_LSB +: 2] == DEV_ADDR);

   // Bit counter; the frame's own select ends it, sck may stop
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         phase <= ST_CMD;
         idx   <= 5'h00;
         sr_in <= 24'h000000;
      end else begin
         sr_in <= {sr_in[22:0], sdi};
         idx   <= (cmd_end || word_end) ? 5'h00 : idx + 5'h01;
         case (phase)
            ST_CMD:  phase <= cmd_end ? ST_DATA : ST_CMD;
            ST_DATA: phase <= ST_DATA;
            default: phase <= ST_CMD;
         endcase
      end
   end

   // Held words plus toggles; held until the next byte group ends
   always_ff @(posedge sck or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_byte <= 8'h00;
         wr_word  <= 24'h000000;
         cmd_tgl  <= 1'b0;
         word_tgl <= 1'b0;
      end else begin
         if (!cs_n && cmd_end) begin
            cmd_byte <= {sr_in[6:0], sdi};
            cmd_tgl  <= ~cmd_tgl;
         end
         if (!cs_n && word_end) begin
            wr_word  <= {sr_in[22:0], sdi};
            word_tgl <= ~word_tgl;
         end
      end
   end

   // Read data out on the falling edge, MSB first
   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         sdo_out <= 1'b0;
         sdo_oe  <= 1'b0;
         out_sr  <= 24'h000000;
      end else begin
         sdo_oe  <= rd_frame;
         sdo_out <= unit_top ? rd_word[23] : out_sr[23]; // Frozen by pause
         out_sr  <= {(unit_top ? rd_word[22:0] : out_sr[22:0]), 1'b0};
      end
   end

   // -------------------------------------------------------------
   // Crossing of the link events into clk
   // -------------------------------------------------------------
   logic [1:0] ev_sync;
   logic       cmd_seen;
   logic       word_seen;

   apg_sync #(.W(2)) u_ev_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .d       ({word_tgl, cmd_tgl}),
      .q       (ev_sync)
   );

   wire cmd_ev  = ev_sync[0] ^ cmd_seen;
   wire word_ev = ev_sync[1] ^ word_seen;

   // -------------------------------------------------------------
   // Register file and address counter
   // -------------------------------------------------------------
   logic [4:0]  addr;
   logic        is_rd;
   logic        hit;
   logic        load_rd;
   logic [23:0] phase_q;
   logic [23:0] gain_q;
   logic [23:0] stat_q;
   logic [7:0]  ready_flags;
   logic [7:0]  pend;
   logic        err_lock;

   // Next address after one word; reads and writes step differently
   wire [4:0] addr_inc  = addr + 5'h01;
   wire [1:0] rd_mode   = stat_q[RD_INC_LSB +: 2];
   wire [4:0] grp_next  = (addr == GRP_LAST) ? GRP_FIRST : addr_inc;
   wire [4:0] typ_next  = (addr == TYP_LAST) ? TYP_FIRST : addr_inc;
   wire [4:0] wr_next   = (addr == WR_LAST)  ? WR_FIRST  : addr_inc;
   wire [4:0] rd_next   = (rd_mode == INC_NONE)  ? addr     :
                          (rd_mode == INC_GROUP) ? grp_next :
                          (rd_mode == INC_TYPE)  ? typ_next :
                          addr_inc;          // Whole map wraps at 5 bits
   wire [4:0] next_addr = is_rd ? rd_next :
                          stat_q[WR_INC_BIT] ? wr_next : addr;
   // Decode of the finished word
   wire wr_hit    = word_ev && hit && !is_rd;
   wire rd_done   = word_ev && hit && is_rd;
   wire wr_phase  = wr_hit && (addr == ADR_PHASE);
   wire wr_gain   = wr_hit && (addr == ADR_GAIN);
   wire wr_stat   = wr_hit && (addr == ADR_STAT);
   wire rd_stat   = rd_done && (addr == ADR_STAT);

   // Read view; reserved and unimplemented bits read zero
   wire [23:0] stat_view = stat_q | {16'h0000, ready_flags};
   wire [23:0] rd_view   = (addr == ADR_PHASE) ? phase_q :
                           (addr == ADR_GAIN)  ? gain_q  :
                           (addr == ADR_STAT)  ? stat_view :
                           24'h000000;

   // Command and word bookkeeping
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmd_seen  <= 1'b0;
         word_seen <= 1'b0;
         addr      <= 5'h00;
         is_rd     <= 1'b0;
         hit       <= 1'b0;
         load_rd   <= 1'b0;
         rd_word   <= 24'h000000;
      end else begin
         cmd_seen  <= ev_sync[0];
         word_seen <= ev_sync[1];
         load_rd   <= cmd_ev | word_ev;
         if (cmd_ev) begin
            addr  <= cmd_byte[CMD_ADR_LSB +: 5];
            is_rd <= cmd_byte[CMD_RD_BIT];
            hit   <= cmd_byte[CMD_DEV_LSB +: 2] == DEV_ADDR;
         end else if (word_ev) begin
            addr  <= next_addr;
         end
         if (load_rd)
            rd_word <= rd_view;       // Frozen so sck never sees it move
      end
   end

   // Writable registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phase_q     <= PHASE_RST;
         gain_q      <= GAIN_RST;
         stat_q      <= STAT_RST;
         adc_restart <= 1'b0;
      end else begin
         adc_restart <= wr_phase;
         if (wr_phase)
            phase_q <= wr_word;
         if (wr_gain)
            gain_q  <= wr_word;
         if (wr_stat)
            stat_q  <= wr_word & STAT_WMASK;
      end
   end

   // Control fields straight from the registers
   assign delay_ch0_vs_ch1     = phase_q[DLY_A_LSB +: DLY_W];
   assign delay_ch2_vs_ch3     = phase_q[DLY_B_LSB +: DLY_W];
   assign rd_incr_mode         = stat_q[RD_INC_LSB +: 2];
   assign wr_incr              = stat_q[WR_INC_BIT];
   assign out_format           = stat_q[FMT_LSB +: 2];
   assign crc_wide             = stat_q[CRCW_BIT];
   assign comm_checksum_enable = stat_q[CRC_EN_BIT];

   // -------------------------------------------------------------
   // Gain decode
   // -------------------------------------------------------------
   logic [23:0] next_gain;

   // Reserved codes fold to unity gain
   for (genvar g = 0; g < 8; g++) begin : g_gain
      assign next_gain[g*GAIN_W +: GAIN_W] =
         (gain_q[g*GAIN_W +: GAIN_W] > GAIN_MAX) ? GAIN_UNITY
                                                 : gain_q[g*GAIN_W +: GAIN_W];
   end

   always_ff @(posedge clk) begin
      if (sys_rst)
         gain_shift <= GAIN_RST;
      else
         gain_shift <= next_gain;
   end

   // -------------------------------------------------------------
   // Ready flags and ready pin
   // -------------------------------------------------------------
   // New data beats a same-cycle status read, so no event is lost
   wire [7:0] next_flags = (ready_flags | {8{rd_stat}}) & ~ch_new;
   wire       merge      = stat_q[MERGE_BIT];
   wire [7:0] pend_all   = pend | ch_new;
   wire       merged_ev  = &pend_all;
   wire       pulse_ev   = merge ? merged_ev : |ch_new;
   wire [7:0] next_pend  = (merge && !merged_ev) ? pend_all : 8'h00;
   wire       next_lock  = (stat_q[ERR_EN_BIT] && cfg_crc_err) ||
                           (err_lock && lock_value != UNLOCK_KEY);
   wire       next_low   = err_lock || pulse_ev;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ready_flags          <= FLAGS_RST;
         pend                 <= 8'h00;
         err_lock             <= 1'b0;
         data_ready_output_n  <= 1'b1;
         data_ready_output_oe <= 1'b0;
      end else begin
         ready_flags          <= next_flags;
         pend                 <= next_pend;
         err_lock             <= next_lock;
         data_ready_output_n  <= !next_low;
         data_ready_output_oe <= next_low || stat_q[IDLE_HI_BIT];
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_restart;
      wr_phase |=> adc_restart ##1 !adc_restart;
   endproperty
   a_restart: assert property (p_restart) else $error("bad restart");
   property p_dly_b;
      wr_phase |=> ##1 delay_ch2_vs_ch3 == $past(wr_word[23:12], 2);
   endproperty
   a_dly_b: assert property (p_dly_b) else $error("upper delay wrong");
   property p_dly_a;
      wr_phase |=> ##1 delay_ch0_vs_ch1 == $past(wr_word[11:0], 2);
   endproperty
   a_dly_a: assert property (p_dly_a) else $error("lower delay wrong");
   property p_gain_ok;
      gain_q[2:0] <= GAIN_MAX |=> gain_shift[2:0] == $past(gain_q[2:0]);
   endproperty
   a_gain_ok: assert property (p_gain_ok) else $error("gain not kept");
   property p_gain_rsv;
      gain_q[5:3] > GAIN_MAX |=> gain_shift[5:3] == GAIN_UNITY;
   endproperty
   a_gain_rsv: assert property (p_gain_rsv) else $error("not unity");
   property p_rd_hold;
      (rd_done && rd_incr_mode == INC_NONE) |=> $stable(addr);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("addr moved");
   property p_wr_wrap;
      (wr_hit && wr_incr && addr == WR_LAST) |=> addr == WR_FIRST;
   endproperty
   a_wr_wrap: assert property (p_wr_wrap) else $error("no addr wrap");
   property p_idle;
      (data_ready_output_oe && data_ready_output_n) |->
         $past(stat_q[IDLE_HI_BIT]);
   endproperty
   a_idle: assert property (p_idle) else $error("idle level wrong");
   property p_unlinked;
      (!merge && ch_new != 8'h00) |=>
         !data_ready_output_n && data_ready_output_oe;
   endproperty
   a_unlinked: assert property (p_unlinked) else $error("no pulse");
   property p_lock;
      err_lock |=> !data_ready_output_n;
   endproperty
   a_lock: assert property (p_lock) else $error("pin not held low");
   // New data clears the flag, which then holds until a status read
   property p_flag;
      (ch_new[0] || (!ready_flags[0] && !rd_stat)) |=> !ready_flags[0];
   endproperty
   a_flag: assert property (p_flag) else $error("flag lost");
   // Only the status word has these bits forced; other words carry data
   property p_unimp;
      (load_rd && addr == ADR_STAT) |=> rd_word[13:8] == 6'h00;
   endproperty
   a_unimp: assert property (p_unimp) else $error("bits 13-8 set");
   c_stat_read: cover property (rd_stat && ready_flags != FLAGS_RST);
   c_merged:    cover property (merge && merged_ev);
   c_unlock:    cover property (err_lock ##1 !err_lock);

endmodule

// ==== hw/apg_pkg.sv ====
// Constants for the phase, gain and status register slice.
// Assumes 5-bit register addresses and 24-bit register words.
package apg_pkg;

   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam logic [4:0] ADR_PHASE = 5'h0a;
   localparam logic [4:0] ADR_GAIN  = 5'h0b;
   localparam logic [4:0] ADR_STAT  = 5'h0c;
   // Address loops for the auto-increment modes
   localparam logic [4:0] GRP_FIRST = 5'h0a;
   localparam logic [4:0] GRP_LAST  = 5'h0c;
   localparam logic [4:0] TYP_FIRST = 5'h09;
   localparam logic [4:0] TYP_LAST  = 5'h0f;
   localparam logic [4:0] WR_FIRST  = 5'h09;
   localparam logic [4:0] WR_LAST   = 5'h1f;

   // -------------------------------------------------------------
   // Command byte and field positions
   // -------------------------------------------------------------
   localparam int unsigned CMD_DEV_LSB = 6;
   localparam int unsigned CMD_ADR_LSB = 1;
   localparam int unsigned CMD_RD_BIT  = 0;
   localparam int unsigned DLY_A_LSB   = 0;
   localparam int unsigned DLY_B_LSB   = 12;
   localparam int unsigned DLY_W       = 12;
   localparam int unsigned GAIN_W      = 3;
   localparam int unsigned RD_INC_LSB  = 22;
   localparam int unsigned WR_INC_BIT  = 21;
   localparam int unsigned IDLE_HI_BIT = 20;
   localparam int unsigned MERGE_BIT   = 19;
   localparam int unsigned CRCW_BIT    = 18;
   localparam int unsigned FMT_LSB     = 16;
   localparam int unsigned CRC_EN_BIT  = 15;
   localparam int unsigned ERR_EN_BIT  = 14;

   // -------------------------------------------------------------
   // Reset values, masks and codes
   // -------------------------------------------------------------
   localparam logic [23:0] PHASE_RST   = 24'h000000;
   localparam logic [23:0] GAIN_RST    = 24'h000000;
   localparam logic [23:0] STAT_RST    = 24'ha90000;
   localparam logic [23:0] STAT_WMASK  = 24'hffc000;
   localparam logic [7:0]  FLAGS_RST   = 8'hff;
   localparam logic [2:0]  GAIN_MAX    = 3'h5;
   localparam logic [2:0]  GAIN_UNITY  = 3'h0;
   localparam logic [7:0]  UNLOCK_KEY  = 8'ha5;
   localparam logic [1:0]  INC_NONE    = 2'h0;
   localparam logic [1:0]  INC_GROUP   = 2'h1;
   localparam logic [1:0]  INC_TYPE    = 2'h2;

   // Serial frame phase, Gray ordered
   typedef enum logic [0:0] {
      ST_CMD  = 1'h0,
      ST_DATA = 1'h1
   } apg_phase_t;

endpackage

// ==== hw/apg_sync.sv ====
// Two-stage level synchroniser into the clk domain.
// Assumes the input bits change no faster than the clk period.
`timescale 1ns/1ps
module apg_sync #(
   parameter int unsigned W = 1
)(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta;

   // First stage feeds only the second
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

// ==== verif/apg_host.sv ====
// Serial host model: select, command byte and 24-bit words.
// Assumes mode 0 timing and a pause with sck high after each unit.
`timescale 1ns/1ps
module apg_host (
   output logic      sck,
   output logic      cs_n,
   output logic      sdi,
   input  wire logic sdo_out,
   input  wire logic sdo_oe
);
   logic sdo_w;
   logic sdo_last = 1'b0;
   logic oe_seen  = 1'b0;

   // ---------------------------------------------------------------
   // Line model
   // ---------------------------------------------------------------
   // Released line shows the inverse of the last bit, never a held one
   assign sdo_w = sdo_oe ? sdo_out : ~sdo_last;
   // Track the line and whether the device ever drove it
   always @(posedge sck) begin
      sdo_last <= sdo_w;
      if (sdo_oe)
         oe_seen <= 1'b1;
   end
   initial begin
      sck  = 1'b0;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end

   // ---------------------------------------------------------------
   // Frame tasks
   // ---------------------------------------------------------------
   // Drive on the low phase, sample just before the rising edge
   task automatic bit1(input logic b, inout logic [23:0] r);
      sck = 1'b0;
      sdi = b;
      #3;
      r = {r[22:0], sdo_w};
      sck = 1'b1;
      #3;
   endtask
   // Pause lets the system side step the address and freeze read data
   task automatic start(input logic [7:0] c);
      logic [23:0] r;
      r = 24'h0;
      cs_n = 1'b0;
      #20;
      for (int i = 7; i >= 0; i--)
         bit1(c[i], r);
      #90;
   endtask
   task automatic word(input logic [23:0] w, output logic [23:0] r);
      r = 24'h0;
      for (int i = 23; i >= 0; i--)
         bit1(w[i], r);
      #90;
   endtask
   // Clock back to idle before deselect; gap covers two system clocks
   task automatic stop();
      sck = 1'b0;
      #20;
      cs_n = 1'b1;
      #30;
   endtask
endmodule

// ==== verif/afe_phase_gain_status_regs_tb.sv ====
// Self-checking bench for the phase, gain and status registers.
// Assumes apg_pkg, apg_regs and the apg_host serial model.
`timescale 1ns/1ps
module afe_phase_gain_status_regs_tb
   import apg_pkg::*;
;
   localparam logic [1:0]  DEV = 2'h1; // Arbitrary device address
   localparam logic [23:0] P   = 24'h123456;
   localparam logic [23:0] G   = 24'hfac688;
   logic        clk         = 1'b0;
   logic        sys_rst     = 1'b1;
   logic [7:0]  ch_new      = 8'h00;
   logic        cfg_crc_err = 1'b0;
   logic [7:0]  lock_value  = 8'h00;
   logic        sck, cs_n, sdi, sdo_out, sdo_oe, adc_restart, wr_incr;
   logic        crc_wide, comm_checksum_enable;
   logic        data_ready_output_n, data_ready_output_oe;
   logic [11:0] delay_ch0_vs_ch1, delay_ch2_vs_ch3;
   logic [23:0] gain_shift, r;
   logic [1:0]  rd_incr_mode, out_format;
   wire  [23:0] ctl = {16'h0, rd_incr_mode, wr_incr, out_format,
                       crc_wide, comm_checksum_enable, data_ready_output_oe};
   wire  [23:0] drp = {22'h0, data_ready_output_oe, data_ready_output_n};
   int          fails = 0;
   int          total_checks = 0;
   int          restarts = 0;
   int          lows = 0;
   int          cycles = 0;
   int          l0;

   apg_regs #(.DEV_ADDR(DEV)) DUT (
      .clk(clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .sdi(sdi),
      .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ch_new(ch_new),
      .cfg_crc_err(cfg_crc_err), .lock_value(lock_value),
      .adc_restart(adc_restart), .delay_ch0_vs_ch1(delay_ch0_vs_ch1),
      .delay_ch2_vs_ch3(delay_ch2_vs_ch3), .gain_shift(gain_shift),
      .rd_incr_mode(rd_incr_mode), .wr_incr(wr_incr),
      .out_format(out_format), .crc_wide(crc_wide),
      .comm_checksum_enable(comm_checksum_enable),
      .data_ready_output_n(data_ready_output_n),
      .data_ready_output_oe(data_ready_output_oe));
   apg_host host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo_out(sdo_out),
      .sdo_oe(sdo_oe));

   // ---------------------------------------------------------------
   // Clock, monitors and tasks
   // ---------------------------------------------------------------
   initial begin
      forever #5 clk = ~clk;
   end
   // Restart pulses, driven-low ready cycles and the run limit
   always @(negedge clk) begin
      cycles++;
      if (adc_restart === 1'b1)
         restarts++;
      if (data_ready_output_oe === 1'b1 && data_ready_output_n === 1'b0)
         lows++;
      if (cycles == 20000) begin
         fails++;
         final_report();
      end
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Reads compare every word; writes send them
   task automatic xfer(input logic [7:0] c, input logic [23:0] q[$]);
      logic [23:0] rx;
      host.start(c);
      foreach (q[i]) begin
         host.word(c[0] ? 24'h0 : q[i], rx);
         if (c[0])
            chk(rx, q[i]);
      end
      host.stop();
      repeat (6) @(negedge clk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [23:0] q[$]);
      xfer({DEV, a, 1'b0}, q);
   endtask
   task automatic rd(input logic [4:0] a, input logic [23:0] q[$]);
      xfer({DEV, a, 1'b1}, q);
   endtask
   // Status writes through this task always put zero into the reserved pair
   task automatic set_stat(input logic [23:0] v);
      wr(ADR_STAT, '{v & 24'hffcfff});
   endtask
   task automatic pulse(input logic [7:0] m);
      ch_new = m;
      @(negedge clk);
      ch_new = 8'h00;
   endtask
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(negedge clk);
      sys_rst = 1'b0;
      repeat (3) @(negedge clk);
      chk(ctl, 24'h0000a8);
      rd(ADR_STAT, '{24'ha900ff});
      // Auto-increment across all three registers, unimplemented bits set
      wr(ADR_PHASE, '{P, G, 24'h77cfff});
      chk(24'(restarts), 24'h1);
      chk({delay_ch2_vs_ch3, delay_ch0_vs_ch1}, P);
      chk(gain_shift, 24'h02c688);
      chk(ctl, 24'h00007f);
      rd(ADR_PHASE, '{P, G, 24'h77c0ff, P});
      // Separate ready pulse, idle high, flags set back to one by a status read
      pulse(8'h24);
      chk(drp, 24'h2);
      @(negedge clk);
      chk(drp, 24'h3);
      rd(ADR_STAT, '{24'h77c0db});
      rd(ADR_STAT, '{24'h77c0ff});
      // Every read stepping mode and every word format
      set_stat(24'h34c000);
      rd(ADR_GAIN, '{G, G, G});
      chk(24'(out_format), 24'h0);
      set_stat(24'h75c000);
      rd(ADR_STAT, '{24'h75c0ff, P, G});
      chk(24'(out_format), 24'h1);
      set_stat(24'hb6c000);
      rd(5'h0f, '{24'h0, 24'h0, P});
      chk(24'(out_format), 24'h2);
      set_stat(24'hf7c000);
      rd(ADR_GAIN, '{G, 24'hf7c0ff, 24'h0});
      chk(24'(out_format), 24'h3);
      // Fixed write address: second word lands on the same register
      set_stat(24'h17c000);
      wr(ADR_GAIN, '{24'h000001, 24'h000fff});
      rd(ADR_GAIN, '{24'h000fff, 24'h000fff});
      rd(ADR_STAT, '{24'h17c0ff});
      chk(gain_shift, 24'h0);
      chk(24'(restarts), 24'h1);
      // Other device address: ignored, line never driven
      host.oe_seen = 1'b0;
      xfer({2'h2, ADR_GAIN, 1'b0}, '{24'h000007});
      host.start({2'h2, ADR_GAIN, 1'b1});
      host.word(24'h0, r);
      host.stop();
      chk({23'h0, host.oe_seen}, 24'h0);
      rd(ADR_GAIN, '{24'h000fff});
      // Merged ready: one pulse only once the last channel reports
      set_stat(24'h3fc000);
      pulse(8'hff);
      repeat (3) @(negedge clk);
      l0 = lows;
      for (int i = 0; i < 7; i++) begin
         pulse(8'h01 << i);
         @(negedge clk);
      end
      chk(24'(lows - l0), 24'h0);
      pulse(8'h80);
      repeat (3) @(negedge clk);
      chk(24'(lows - l0), 24'h1);
      rd(ADR_STAT, '{24'h3fc000});
      // Write address wraps from the map top to the writable start
      wr(5'h1f, '{24'h0, 24'h0, P});
      chk(24'(restarts), 24'h2);
      // Checksum error holds the pin low until the key is written
      cfg_crc_err = 1'b1;
      @(negedge clk);
      cfg_crc_err = 1'b0;
      repeat (20) @(negedge clk);
      chk(drp, 24'h2);
      lock_value = UNLOCK_KEY;
      repeat (3) @(negedge clk);
      chk(drp, 24'h3);
      final_report();
   end
endmodule
